// File: core/tia_alu.sv
// three-input alu with flag expander, bit detector and status update
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - expander replicates 1/2/4 bits into 32
// - expander fed only by split flags, feeds C
// - expansion size comes from status word field
// - split flags rotate by bits used or set
// - split flags optionally cleared, get segment bits
// - four detections, position reported as 31-index
// - highest or lowest set bit located
// - highest/lowest bit differing from end bit
// - nothing found gives 32 and sets overflow
// - detector result feeds the C port
// - detector use forces four 8-bit segments
// - boolean mode is purely bitwise, no carries
// - arithmetic adds two boolean input combinations
// - carry chain splits into 16 or 8 bits
// - one split flag per segment, selectable kind
// - 8-bit code plus mode picks function
// - base set derives carry-in from code, sign choice from sign_sel
// - extended set takes controls from first data register
// - update negative, carry, overflow, zero flags
// - pc destination leaves flags untouched
// - conditional write updates flags only when written
// - protected flags keep their value
module tia_alu (
  input  wire logic               clk_sys_i,  // core clock, 40 mhz
  input  wire logic               resetn_i,   // asynchronous reset, active low
  input  wire tia_pkg::tia_req_t  req_i,      // operation from the decoder
  input  wire logic               psel_i,     // apb select
  input  wire logic               penable_i,  // apb access phase
  input  wire logic               pwrite_i,   // apb direction
  input  wire logic [11:0]        paddr_i,    // apb byte address
  input  wire logic [31:0]        pwdata_i,   // apb write data
  output logic      [31:0]        prdata_o,   // apb read data
  output logic                    pready_o,   // apb ready
  output logic                    pslverr_o,  // apb error, unmapped address
  output logic      [31:0]        result_o,   // alu result
  output logic                    result_vld_o, // result written this cycle
  output logic      [31:0]        status_o,   // status word
  output logic      [31:0]        splitf_o    // split_flag_register
);
  import tia_pkg::*;

  // ********************************************
  // state
  // ********************************************
  logic [31:0] sw_q;        // status word
  logic [31:0] mf_q;        // split_flag_register
  logic [31:0] res_q;       // last result
  logic        rvld_q;      // result strobe
  logic [31:0] prdata_q;    // apb read data
  logic        pready_q;    // apb ready
  logic        pslverr_q;   // apb error

  // ********************************************
  // function control selection
  // ********************************************
  logic [7:0] fn;           // effective function code
  logic       cin;          // effective carry-in
  logic       sgn_ctl;      // sign-dependent choice enabled

  // base set keys carry-in off the b term table: an inverted b means subtract
  always_comb begin
    if (req_i.ext_op) begin
      fn      = req_i.first_data[7:0];
      cin     = req_i.first_data[TIA_D0_CIN];
      sgn_ctl = req_i.first_data[TIA_D0_SGN];
    end else begin
      fn      = req_i.func;
      cin     = req_i.func[4];
      sgn_ctl = req_i.sign_sel;
    end
    // negative a selects the companion function with the opposite b sense
    if (sgn_ctl && req_i.opnd_a[31]) begin
      fn  = fn ^ 8'hF0;
      cin = ~cin;
    end
  end

  // ********************************************
  // expander
  // ********************************************
  logic [1:0]  msize;       // expansion-size field
  logic [2:0]  exp_bits;    // flag bits consumed: 1, 2 or 4
  logic [31:0] exp_word;    // expanded_flag_operand

  assign msize = sw_q[TIA_SW_MSIZE_LO +: 2];

  always_comb begin
    case (msize)
      2'b00:   exp_bits = 3'd1;
      2'b01:   exp_bits = 3'd2;
      default: exp_bits = 3'd4;
    endcase
  end

  // each output bit picks its source flag by group index
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_exp
      always_comb begin
        case (exp_bits)
          3'd1:    exp_word[gi] = mf_q[0];
          3'd2:    exp_word[gi] = mf_q[gi >> 4];
          default: exp_word[gi] = mf_q[gi >> 3];
        endcase
      end
    end
  endgenerate

  // ********************************************
  // bit detector
  // ********************************************
  logic [31:0] cand;        // bits that qualify
  logic [5:0]  det_val;     // 31 minus index, or 32
  logic        det_none;    // no qualifying bit

  always_comb begin
    case (req_i.det_sel)
      TIA_DET_LMO, TIA_DET_RMO: cand = req_i.opnd_a;
      TIA_DET_LMBC: cand = req_i.opnd_a ^ {32{req_i.opnd_a[31]}};
      default:      cand = req_i.opnd_a ^ {32{req_i.opnd_a[0]}};
    endcase
    det_val = 6'd32;
    if (req_i.det_sel == TIA_DET_LMO || req_i.det_sel == TIA_DET_LMBC) begin
      // ascending scan, last hit is the highest bit
      for (int i = 0; i < 32; i++) begin
        if (cand[i]) begin
          det_val = 6'(31 - i);
        end
      end
    end else begin
      // descending scan, last hit is the lowest bit
      for (int i = 31; i >= 0; i--) begin
        if (cand[i]) begin
          det_val = 6'(31 - i);
        end
      end
    end
    det_none = (cand == 32'h0000_0000);
  end

  // ********************************************
  // alu input ports
  // ********************************************
  logic [31:0] pc;          // c port value
  logic [31:0] pa;          // a port value
  logic [31:0] pb;          // b port value

  assign pa = req_i.opnd_a;
  assign pb = req_i.opnd_b;

  always_comb begin
    if (req_i.det_en) begin
      pc = {26'h0, det_val};
    end else if (req_i.csrc == TIA_CSRC_EXP) begin
      pc = exp_word;
    end else begin
      pc = req_i.opnd_c;
    end
  end

  // ********************************************
  // datapath: boolean, term generation, split adder
  // ********************************************
  tia_split_t  eff_split;   // split after the detector override
  logic [31:0] bool_res;    // boolean mode result
  logic [31:0] t_p;         // first term, table over a and c
  logic [31:0] t_q;         // second term, table over b and c
  logic [31:0] sum;         // arithmetic result
  logic [3:0]  ci;          // carry into each byte
  logic [3:0]  co;          // carry out of each byte
  logic [3:0]  ov;          // signed overflow at each byte top

  assign eff_split = req_i.det_en ? TIA_SPL_8 : req_i.split;

  generate
    for (gi = 0; gi < 32; gi++) begin : g_bit
      assign bool_res[gi] = fn[{pa[gi], pb[gi], pc[gi]}];
      assign t_p[gi]      = fn[{1'b0, pa[gi], pc[gi]}];
      assign t_q[gi]      = fn[{1'b1, pb[gi], pc[gi]}];
    end
    for (gi = 0; gi < 4; gi++) begin : g_byte
      logic [8:0] bsum;     // byte sum with carry-out
      if (gi == 0) begin : g_c0
        assign ci[gi] = cin;
      end else begin : g_cn
        // a segment boundary drops the lower carry and injects its own
        assign ci[gi] = (eff_split == TIA_SPL_8 ||
                         (eff_split == TIA_SPL_16 && gi == 2)) ? cin : co[gi-1];
      end
      assign bsum = {1'b0, t_p[gi*8 +: 8]} + {1'b0, t_q[gi*8 +: 8]} + 9'(ci[gi]);
      assign sum[gi*8 +: 8] = bsum[7:0];
      assign co[gi]         = bsum[8];
      assign ov[gi] = (t_p[gi*8+7] == t_q[gi*8+7]) && (bsum[7] != t_p[gi*8+7]);
    end
  endgenerate

  logic [31:0] res;         // selected result
  assign res = req_i.arith ? sum : bool_res;

  // ********************************************
  // per-segment flags
  // ********************************************
  logic [3:0] f8;           // one flag per byte segment
  logic [1:0] f16;          // one flag per halfword segment
  logic       f32;          // flag of the whole word
  logic [2:0] nseg;         // segments: 1, 2 or 4

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      case (req_i.mf_segf)
        TIA_SEG_CARRY: f8[k] = co[k];
        TIA_SEG_ZERO:  f8[k] = (res[k*8 +: 8] == 8'h00);
        TIA_SEG_SIGN:  f8[k] = res[k*8+7];
        default:       f8[k] = res[k*8+7] ^ ov[k];
      endcase
    end
    for (int k = 0; k < 2; k++) begin
      case (req_i.mf_segf)
        TIA_SEG_CARRY: f16[k] = co[2*k+1];
        TIA_SEG_ZERO:  f16[k] = (res[k*16 +: 16] == 16'h0000);
        TIA_SEG_SIGN:  f16[k] = res[k*16+15];
        default:       f16[k] = res[k*16+15] ^ ov[2*k+1];
      endcase
    end
    case (req_i.mf_segf)
      TIA_SEG_CARRY: f32 = co[3];
      TIA_SEG_ZERO:  f32 = (res == 32'h0000_0000);
      TIA_SEG_SIGN:  f32 = res[31];
      default:       f32 = res[31] ^ ov[3];
    endcase
    case (eff_split)
      TIA_SPL_16: nseg = 3'd2;
      TIA_SPL_8:  nseg = 3'd4;
      default:    nseg = 3'd1;
    endcase
  end

  // ********************************************
  // write qualification and new flags
  // ********************************************
  logic       wr_ok;        // result really written
  logic       upd;          // flags may change
  logic [3:0] nf;           // new flags n c v z

  assign wr_ok = req_i.valid && (!req_i.cond_wr || req_i.cond_true);
  assign upd   = wr_ok && !req_i.dst_is_pc;

  always_comb begin
    nf[3] = res[31];
    nf[2] = req_i.arith ? co[3] : 1'b0;
    nf[1] = req_i.det_en ? det_none : (req_i.arith ? ov[3] : 1'b0);
    nf[0] = (res == 32'h0000_0000);
  end

  // ********************************************
  // apb decode
  // ********************************************
  logic apb_setup;          // setup phase, answered next cycle
  logic apb_wr;             // write taken at this edge
  logic hit_sw;             // status word selected
  logic hit_mf;             // split-flag register selected
  logic hit_res;            // result register selected

  assign apb_setup = psel_i && !penable_i;
  assign apb_wr    = psel_i && penable_i && pwrite_i && pready_q;

  always_comb begin
    hit_sw  = 1'b0;
    hit_mf  = 1'b0;
    hit_res = 1'b0;
    if (paddr_i == TIA_OFS_STATUS) begin
      hit_sw = 1'b1;
    end else if (paddr_i == TIA_OFS_SPLITF) begin
      hit_mf = 1'b1;
    end else if (paddr_i == TIA_OFS_RESULT) begin
      hit_res = 1'b1;
    end
  end

  // one wait-free access: ready and data come up in the access cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup && !(hit_sw || hit_mf || hit_res);
      if (apb_setup && !pwrite_i) begin
        if (hit_sw) begin
          prdata_q <= sw_q;
        end else if (hit_mf) begin
          prdata_q <= mf_q;
        end else if (hit_res) begin
          prdata_q <= res_q;
        end else begin
          prdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  // ********************************************
  // status word: hardware flags win over a same-cycle software write
  // ********************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sw_q <= TIA_SW_RST;
    end else begin
      if (apb_wr && hit_sw) begin
        sw_q <= pwdata_i & TIA_SW_WMASK;
      end
      if (upd) begin
        for (int k = 0; k < 4; k++) begin
          if (!req_i.protect[k]) begin
            sw_q[k] <= nf[k];
          end
        end
      end
    end
  end

  // ********************************************
  // split_flag_register
  // ********************************************
  logic [31:0] mf_base;     // after the optional clear
  logic [31:0] mf_rl;       // base rotated left by the segment count
  logic [31:0] mf_rr;       // rotated right by the bits the expander used

  assign mf_base = req_i.mf_clear ? 32'h0000_0000 : mf_q;
  assign mf_rl   = req_i.mf_rotate ?
                   ((mf_base << nseg) | (mf_base >> (6'd32 - 6'(nseg)))) : mf_base;
  assign mf_rr   = (mf_q >> exp_bits) | (mf_q << (6'd32 - 6'(exp_bits)));

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mf_q <= TIA_SPLITF_RST;
    end else if (req_i.valid && req_i.mf_set) begin
      // new segment flags land in the low bits
      case (nseg)
        3'd1:    mf_q <= {mf_rl[31:1], f32};
        3'd2:    mf_q <= {mf_rl[31:2], f16};
        default: mf_q <= {mf_rl[31:4], f8};
      endcase
    end else if (req_i.valid && req_i.mf_rotate && req_i.csrc == TIA_CSRC_EXP
                 && !req_i.det_en) begin
      mf_q <= mf_rr;
    end else if (apb_wr && hit_mf) begin
      mf_q <= pwdata_i;
    end
  end

  // ********************************************
  // result register
  // ********************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res_q  <= 32'h0000_0000;
      rvld_q <= 1'b0;
    end else begin
      rvld_q <= wr_ok;
      if (wr_ok) begin
        res_q <= res;
      end
    end
  end

  assign prdata_o     = prdata_q;
  assign pready_o     = pready_q;
  assign pslverr_o    = pslverr_q;
  assign result_o     = res_q;
  assign result_vld_o = rvld_q;
  assign status_o     = sw_q;
  assign splitf_o     = mf_q;

  // ********************************************
  // assertions
  // ********************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_flag_write;
    upd && !(apb_wr && hit_sw);
  endsequence

  sequence s_no_sw_change;
    !(apb_wr && hit_sw);
  endsequence

  a_pc_flags_hold: assert property (
    (req_i.valid && req_i.dst_is_pc && !(apb_wr && hit_sw)) |=> $stable(sw_q[3:0]))
    else $error("flags changed on a pc destination");

  a_cond_false_hold: assert property (
    (req_i.valid && req_i.cond_wr && !req_i.cond_true) ##0 s_no_sw_change
      |=> $stable(sw_q[3:0]) && !rvld_q)
    else $error("flags or result changed on a false condition");

  a_protect_hold: assert property (
    s_flag_write ##0 req_i.protect[TIA_SW_Z] |=> $stable(sw_q[TIA_SW_Z]))
    else $error("protected zero flag changed");

  a_det_none_v: assert property (
    s_flag_write ##0 (req_i.det_en && det_none && !req_i.protect[TIA_SW_V])
      |=> sw_q[TIA_SW_V])
    else $error("empty detection did not set overflow");

  a_det_top_bit: assert property (
    (req_i.det_sel == TIA_DET_LMO && req_i.opnd_a[31]) |-> (det_val == 6'd0))
    else $error("leftmost one of bit 31 not reported as 0");

  a_bool_bit0: assert property (
    (wr_ok && !req_i.arith)
      |-> (res[0] == fn[{pa[0], pb[0], pc[0]}]))
    else $error("boolean result bit 0 wrong");

  a_split8_byte1: assert property (
    (wr_ok && req_i.arith && eff_split == TIA_SPL_8)
      |-> (sum[15:8] == 8'(t_p[15:8] + t_q[15:8] + 8'(cin))))
    else $error("byte segment took a foreign carry");

  a_expand_half: assert property (
    (msize == 2'b01) |-> (exp_word[31:16] == {16{mf_q[1]}}))
    else $error("halfword expansion wrong");

  a_mf_clear_set: assert property (
    (req_i.valid && req_i.mf_set && req_i.mf_clear && eff_split == TIA_SPL_8)
      |=> (mf_q[31:4] == 28'h000_0000))
    else $error("cleared split flags kept old bits");

  a_apb_ready: assert property (
    apb_setup |=> pready_o ##1 !pready_o)
    else $error("apb answer not one cycle long");

endmodule

`default_nettype wire

// File: core/tia_pkg.sv
// package: constants, encodings and carriers of the three-input alu block
package tia_pkg;

  // ********************************************
  // register map (byte addresses on apb)
  // ********************************************
  localparam logic [11:0] TIA_OFS_STATUS  = 12'h000; // status word
  localparam logic [11:0] TIA_OFS_SPLITF  = 12'h004; // split-flag register
  localparam logic [11:0] TIA_OFS_RESULT  = 12'h008; // last alu result, read only

  // ********************************************
  // status word fields
  // ********************************************
  localparam int          TIA_SW_Z        = 0;       // zero flag
  localparam int          TIA_SW_V        = 1;       // overflow flag
  localparam int          TIA_SW_C        = 2;       // carry flag
  localparam int          TIA_SW_N        = 3;       // negative flag
  localparam int          TIA_SW_MSIZE_LO = 4;       // expansion-size field low bit
  localparam logic [31:0] TIA_SW_RST      = 32'h0000_0000;
  localparam logic [31:0] TIA_SW_WMASK    = 32'h0000_003F; // writable bits
  localparam logic [31:0] TIA_SPLITF_RST  = 32'h0000_0000;

  // ********************************************
  // enumerations
  // ********************************************
  typedef enum logic [1:0] {
    TIA_SPL_32 = 2'b00,                              // one 32-bit adder
    TIA_SPL_16 = 2'b01,                              // two 16-bit adders
    TIA_SPL_8  = 2'b10                               // four 8-bit adders
  } tia_split_t;

  typedef enum logic [1:0] {
    TIA_DET_LMO  = 2'b00,                            // leftmost one
    TIA_DET_RMO  = 2'b01,                            // rightmost one
    TIA_DET_LMBC = 2'b10,                            // leftmost bit change
    TIA_DET_RMBC = 2'b11                             // rightmost bit change
  } tia_det_t;

  typedef enum logic [1:0] {
    TIA_CSRC_OPND = 2'b00,                           // plain operand from register file
    TIA_CSRC_EXP  = 2'b01,                           // expanded_flag_operand
    TIA_CSRC_DET  = 2'b10                            // bit-detection result when det_en is set, else opnd_c
  } tia_csrc_t;

  typedef enum logic [1:0] {
    TIA_SEG_CARRY = 2'b00,                           // segment carry-out
    TIA_SEG_ZERO  = 2'b01,                           // segment zero compare
    TIA_SEG_SIGN  = 2'b10,                           // segment sign bit
    TIA_SEG_XSIGN = 2'b11                            // sign corrected by overflow
  } tia_segf_t;

  // extended_function_op control fields inside first_data_register
  localparam int TIA_D0_CIN  = 8;                    // carry-in bit
  localparam int TIA_D0_SGN  = 9;                    // conditional sign control bit

  // ********************************************
  // request carrier from the instruction decoder
  // ********************************************
  typedef struct packed {
    logic        valid;        // one operation this cycle
    logic        arith;        // 1 arithmetic, 0 boolean
    logic        ext_op;       // extended_function_op: controls from first_data_register
    logic [7:0]  func;         // base-set function code
    logic        sign_sel;     // base set: pick alternate function on negative a
    tia_split_t  split;        // requested carry split
    tia_csrc_t   csrc;         // c port source
    logic        det_en;       // operation uses the bit detector
    tia_det_t    det_sel;      // which detection
    logic        dst_is_pc;    // result goes to the program counter
    logic        cond_wr;      // write-back is conditional
    logic        cond_true;    // condition outcome
    logic [3:0]  protect;      // per-flag protection, bit order n c v z
    logic        mf_rotate;    // rotate split_flag_register
    logic        mf_set;       // multiple arithmetic: write segment flags
    logic        mf_clear;     // clear before the segment flags go in
    tia_segf_t   mf_segf;      // which segment flag to write
    logic [31:0] opnd_a;       // a port operand (also detector source)
    logic [31:0] opnd_b;       // b port operand
    logic [31:0] opnd_c;       // c port operand
    logic [31:0] first_data;   // first_data_register contents
  } tia_req_t;

endpackage

// File: verif/three_input_alu_expander_bitdetect_bench.sv
// self-checking bench of the three-input alu block
`timescale 1ns/100ps
`default_nettype none
module three_input_alu_expander_bitdetect_bench;
  import tia_pkg::*;
  logic        clk_sys_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, result_o, status_o, splitf_o, e;
  logic        pready_o, pslverr_o, result_vld_o, err;
  logic [32:0] w33;
  tia_req_t    req_i, r;
  int          failures = 0, total_checks = 0, cyc = 0;
  logic [31:0] exp_q[$];
  logic [31:0] dsrc[5] = '{32'h0001_0000, 32'h0001_0000, 32'hFFFF_0000, 32'h0000_00FF, 32'h0};
  logic [5:0]  dval[5] = '{6'h0F, 6'h0F, 6'h10, 6'h17, 6'h20};
  always #12.5 clk_sys_i = ~clk_sys_i;
  tia_dec_model dec (.clk_sys_i(clk_sys_i), .req_o(req_i));
  tia_alu dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .result_o(result_o),
    .result_vld_o(result_vld_o), .status_o(status_o), .splitf_o(splitf_o));
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
    total_checks++;
    if (s !== ex) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, ex, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // apb master: request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    psel_i <= 1'b1; pwrite_i <= wr; paddr_i <= ad; pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    // no fixed wait assumed; only the hang guard ends a missing answer
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    err = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
    // one idle edge so psel is never lowered and raised in one time step
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] ex);
    exp_q.push_back(ex);
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic op(input logic [31:0] ex, input logic wr = 1'b1);
    if (wr) exp_q.push_back(ex);
    dec.issue(r);
    @(posedge clk_sys_i);
  endtask
  task automatic setr();
    r = '0;
    r.valid = 1'b1;
  endtask
  function automatic logic [31:0] boolf(input logic [7:0] f, input logic [31:0] x, y, z);
    for (int i = 0; i < 32; i++) boolf[i] = f[{x[i], y[i], z[i]}];
  endfunction
  // carry restarts at each segment boundary
  function automatic logic [31:0] sadd(input logic [31:0] x, y, input int w);
    logic cy;
    cy = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (i % w == 0) cy = 1'b0;
      sadd[i] = x[i] ^ y[i] ^ cy;
      cy = (x[i] & y[i]) | (cy & (x[i] ^ y[i]));
    end
  endfunction
  // the watcher: each result pulse or read answer takes the oldest note
  always @(posedge clk_sys_i) begin
    if (result_vld_o === 1'b1 || (pready_o === 1'b1 && pwrite_i === 1'b0)) begin
      if (exp_q.size() == 0) chk("spurious", 32'h0, 32'h1);
      else chk("output", exp_q.pop_front(), result_vld_o ? result_o : prdata_o);
    end
  end
  // hang guard, far above the eighty or so cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin failures++; report_and_stop(); end
  end
  initial begin
    void'($urandom(78));
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(TIA_OFS_STATUS, TIA_SW_RST);
    rd(TIA_OFS_SPLITF, TIA_SPLITF_RST);
    rd(12'hFFC, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test registers done");
    for (int t = 0; t < 8; t++) begin
      setr(); r.func = 8'($urandom); r.opnd_a = $urandom; r.opnd_b = $urandom; r.opnd_c = $urandom;
      e = boolf(r.func, r.opnd_a, r.opnd_b, r.opnd_c);
      op(e);
      chk("flags", {28'h0, e[31], 2'b00, e == 0}, status_o & 32'hF);
    end
    for (int s = 0; s < 3; s++) begin
      setr(); r.arith = 1'b1; r.func = 8'hCC; r.split = tia_split_t'(s);
      r.opnd_a = $urandom | 32'h8080_8080; r.opnd_b = $urandom | 32'h8080_8080;
      op(sadd(r.opnd_a, r.opnd_b, 32 >> s));
    end
    for (int k = 0; k < 2; k++) begin
      // 3C is a - b with carry-in 1; a negative a flips it to a + b
      setr(); r.arith = 1'b1; r.func = 8'h3C; r.sign_sel = 1'b1;
      r.opnd_a = {k[0], 31'($urandom)}; r.opnd_b = $urandom;
      w33 = {1'b0, r.opnd_a} + {1'b0, (k == 0) ? ~r.opnd_b : r.opnd_b} + 33'(k == 0);
      op(w33[31:0]);
      chk("carry", {31'h0, w33[32]}, {31'h0, status_o[TIA_SW_C]});
    end
    $display("test alu modes done");
    apb(1'b1, TIA_OFS_STATUS, 32'h10);
    apb(1'b1, TIA_OFS_SPLITF, 32'hA);
    setr(); r.ext_op = 1'b1; r.first_data = 32'hAA; r.csrc = TIA_CSRC_EXP; r.mf_rotate = 1'b1;
    op(32'hFFFF_0000);
    rd(TIA_OFS_SPLITF, 32'h8000_0002);
    for (int i = 0; i < 5; i++) begin
      setr(); r.det_en = 1'b1; r.det_sel = tia_det_t'(i % 4); r.csrc = TIA_CSRC_DET;
      r.func = 8'hAA; r.opnd_a = dsrc[i];
      op({26'h0, dval[i]});
      chk("ovf", {31'h0, dval[i] == 6'h20}, {31'h0, status_o[TIA_SW_V]});
    end
    setr(); r.det_en = 1'b1; r.arith = 1'b1; r.func = 8'hCC; r.opnd_a = 32'hFF; r.opnd_b = 32'h1;
    op(32'h0);
    $display("test expander and detector done");
    setr(); r.func = 8'hFF;
    op(32'hFFFF_FFFF);
    setr(); r.dst_is_pc = 1'b1;
    op(32'h0);
    chk("pc flags", 32'h8, status_o & 32'hF);
    setr(); r.cond_wr = 1'b1;
    op(32'h0, 1'b0);
    chk("cond flags", 32'h8, status_o & 32'hF);
    setr(); r.protect = 4'h1;
    op(32'h0);
    chk("prot flags", 32'h0, status_o & 32'hF);
    setr(); r.arith = 1'b1; r.func = 8'hCC; r.split = TIA_SPL_8; r.mf_set = 1'b1;
    r.mf_clear = 1'b1; r.mf_segf = TIA_SEG_ZERO; r.opnd_a = 32'h00FF_0000;
    op(32'h00FF_0000);
    chk("splitf", 32'hB, splitf_o);
    $display("test flags done");
    repeat (3) @(posedge clk_sys_i);
    chk("queue", 32'h0, exp_q.size());
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: verif/tia_dec_model.sv
// decoder stand-in that hands one operation to the alu
`timescale 1ns/100ps
`default_nettype none
module tia_dec_model (
  input  wire logic            clk_sys_i, // core clock
  output var tia_pkg::tia_req_t req_o     // request toward the alu
);
  import tia_pkg::*;
  initial req_o = '0;
  // valid stands for exactly one edge, so one call is one operation
  task automatic issue(input tia_req_t q);
    req_o <= q;
    @(posedge clk_sys_i);
    req_o.valid <= 1'b0;
  endtask
endmodule
`default_nettype wire
